// ==== design/ucip_regs.vh ====
`ifndef UCIP_REGS_VH
`define UCIP_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define UCIP_ADDR_RHR 3'h0
`define UCIP_ADDR_THR 3'h0
`define UCIP_ADDR_IER 3'h1
`define UCIP_ADDR_ISR 3'h2
`define UCIP_ADDR_FCR 3'h2
`define UCIP_ADDR_FEAT 3'h3
`define UCIP_ADDR_EFR 3'h4
`define UCIP_ADDR_LSR 3'h5
`define UCIP_ADDR_MSR 3'h6
`define UCIP_ADDR_GIRQ 3'h7
// ****************************************
// Field positions
// ****************************************
`define UCIP_IE_RX 0
`define UCIP_IE_TX 1
`define UCIP_IE_LS 2
`define UCIP_IE_MS 3
`define UCIP_IE_XOFF 5
`define UCIP_IE_RTS 6
`define UCIP_IE_CTS 7
`define UCIP_FCR_EN 0
`define UCIP_FEAT_RS485 5
`define UCIP_EFR_ENH 4
// ****************************************
// Reset values and source codes
// ****************************************
`define UCIP_RST_8 8'h00
`define UCIP_CODE_LS 6'h06
`define UCIP_CODE_RX 6'h04
`define UCIP_CODE_TO 6'h0c
`define UCIP_CODE_TX 6'h02
`define UCIP_CODE_MS 6'h00
`define UCIP_CODE_XS 6'h10
`define UCIP_CODE_PIN 6'h20
`define UCIP_CODE_NONE 6'h01
// ****************************************
// Time-out: 4 chars plus 12 bits
// ****************************************
`define UCIP_TO_CHARS 4
`define UCIP_TO_BITS 12
`endif

// ==== design/ucip_trig_table.v ====
`include "ucip_regs.vh"
// ****************************************
// Trigger level lookup
// ****************************************
module ucip_trig_table (
  input wire [1:0] table_sel,
  input wire [1:0] rx_sel,
  input wire [1:0] tx_sel,
  input wire [6:0] rx_prog,
  input wire [6:0] tx_prog,
  output reg [6:0] rx_level,
  output reg [6:0] tx_level
);
  always @* begin
    rx_level = 7'h01;
    tx_level = 7'h01;
    case (table_sel)
      2'h0: begin
        case (rx_sel)
          2'h0: rx_level = 7'h01;
          2'h1: rx_level = 7'h04;
          2'h2: rx_level = 7'h08;
          default: rx_level = 7'h0e;
        endcase
        tx_level = 7'h01;
      end
      2'h1: begin
        case (rx_sel)
          2'h0: rx_level = 7'h08;
          2'h1: rx_level = 7'h10;
          2'h2: rx_level = 7'h18;
          default: rx_level = 7'h1c;
        endcase
        case (tx_sel)
          2'h0: tx_level = 7'h10;
          2'h1: tx_level = 7'h08;
          2'h2: tx_level = 7'h18;
          default: tx_level = 7'h1e;
        endcase
      end
      2'h2: begin
        case (rx_sel)
          2'h0: rx_level = 7'h08;
          2'h1: rx_level = 7'h10;
          2'h2: rx_level = 7'h38;
          default: rx_level = 7'h3c;
        endcase
        case (tx_sel)
          2'h0: tx_level = 7'h08;
          2'h1: tx_level = 7'h10;
          2'h2: tx_level = 7'h20;
          default: tx_level = 7'h38;
        endcase
      end
      default: begin
        rx_level = rx_prog;
        tx_level = tx_prog;
      end
    endcase
  end
endmodule // ucip_trig_table

// ==== design/ucip_irq.v ====
// The strobed register port and the register addresses are this design's own decisions.
`include "ucip_regs.vh"
// Overview of operation
// - Non-FIFO: TX interrupt when holding empty
// - FIFO: TX interrupt below trigger, then empty
// - Half-duplex mode waits for shifter empty
// - TX enable resets off, one enables
// - RX interrupt on data or trigger level
// - Report highest pending, hold until serviced
// - Codes: line status 06, rx data 04
// - Codes: timeout 0c, tx 02, modem 00
// - Codes: special 10, pin 20, none 01
// - Line status bits 4..1 raise interrupt
// - Timeout after four chars plus twelve bits
// - Modem deltas and xoff/special raise interrupts
// - Flow pin rising edge raises interrupt
// - Line, rx level, timeout clearing conditions
// - TX cleared by source read or write
// - Modem status read clears modem, pin
// - Xoff/special cleared by read or character
// - Wake-up set on leaving sleep, global read clears
// - Source bits 7:6 show FIFO enable
// - Source bit 0 low while pending
// - RX trigger select within chosen table
// - TX trigger writable only when enhanced
// - Last table selection applies to both
module ucip_irq #(
  parameter CNT_W = 7,
  parameter TO_W = 12
) (
  input wire clk,
  input wire rst,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  input wire [CNT_W-1:0] rx_count,
  input wire [CNT_W-1:0] tx_count,
  input wire tx_shift_empty,
  input wire rx_char_in,
  input wire [4:0] bit_clocks,
  input wire [3:0] char_bits,
  input wire [7:0] line_status,
  input wire [3:0] modem_delta,
  input wire xoff_seen,
  input wire special_seen,
  input wire xon_seen,
  input wire auto_flow,
  input wire cts_pin,
  input wire rts_out,
  input wire sleep_mode,
  input wire [CNT_W-1:0] rx_prog,
  input wire [CNT_W-1:0] tx_prog,
  output reg fifo_en,
  output reg wake_flag,
  output reg irq
);
// ****************************************
// Synchronisers and edge detect
// ****************************************
  reg cts_s1, cts_s2, cts_d, slp_s1, slp_s2, slp_d;
  always @(posedge clk) begin
    if (rst) begin
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
      cts_d <= 1'b0;
      slp_s1 <= 1'b0;
      slp_s2 <= 1'b0;
      slp_d <= 1'b0;
    end else begin
      cts_s1 <= cts_pin;
      cts_s2 <= cts_s1;
      cts_d <= cts_s2;
      slp_s1 <= sleep_mode;
      slp_s2 <= slp_s1;
      slp_d <= slp_s2;
    end
  end
  reg rts_d;
  always @(posedge clk) begin
    if (rst) begin
      rts_d <= 1'b0;
    end else begin
      rts_d <= rts_out;
    end
  end
  wire cts_rise = cts_s2 & ~cts_d;
  wire rts_rise = rts_out & ~rts_d;
  wire wake_rise = slp_d & ~slp_s2;
// ****************************************
// Registers
// ****************************************
  reg [7:0] irq_enable_reg;
  reg [7:0] feature_ctrl_reg;
  reg [7:0] enhanced_feature_reg;
  reg [1:0] rx_sel, tx_sel;
  wire enh = enhanced_feature_reg[`UCIP_EFR_ENH];
  wire fcr_wr = wr && addr == `UCIP_ADDR_FCR;
  wire fcr_take = fcr_wr && wdata[`UCIP_FCR_EN];
  always @(posedge clk) begin
    if (rst) begin
      irq_enable_reg <= `UCIP_RST_8;
      feature_ctrl_reg <= `UCIP_RST_8;
      enhanced_feature_reg <= `UCIP_RST_8;
      fifo_en <= 1'b0;
      rx_sel <= 2'h0;
      tx_sel <= 2'h0;
    end else begin
      if (wr && addr == `UCIP_ADDR_IER) begin
        irq_enable_reg <= enh ? wdata : {3'h0, wdata[4:0]};
      end
      if (wr && addr == `UCIP_ADDR_FEAT) begin
        feature_ctrl_reg <= wdata;
      end
      if (wr && addr == `UCIP_ADDR_EFR) begin
        enhanced_feature_reg <= wdata;
      end
      if (fcr_wr) begin
        fifo_en <= wdata[`UCIP_FCR_EN];
      end
      if (fcr_take) begin
        rx_sel <= wdata[7:6];
        if (enh) begin
          tx_sel <= wdata[5:4];
        end
      end
    end
  end
  wire [6:0] rx_level, tx_level;
  ucip_trig_table u_table (
    .table_sel(feature_ctrl_reg[7:6]),
    .rx_sel(rx_sel),
    .tx_sel(tx_sel),
    .rx_prog(rx_prog),
    .tx_prog(tx_prog),
    .rx_level(rx_level),
    .tx_level(tx_level)
  );
// ****************************************
// Sources
// ****************************************
  wire rd_isr = rd && addr == `UCIP_ADDR_ISR;
  wire rd_lsr = rd && addr == `UCIP_ADDR_LSR;
  wire rd_msr = rd && addr == `UCIP_ADDR_MSR;
  wire rd_rhr = rd && addr == `UCIP_ADDR_RHR;
  wire rd_gir = rd && addr == `UCIP_ADDR_GIRQ;
  wire wr_thr = wr && addr == `UCIP_ADDR_THR;
  // Level source: clears by itself as reads drain the FIFO
  wire rx_pend = fifo_en ? (rx_count >= rx_level) : (rx_count != 7'h00);
  reg ls_pend, to_pend, tx_pend, ms_pend, xs_pend, pin_pend;
  reg [5:0] cur_code;
  reg [5:0] held_code;
  reg still_pending;
  reg [CNT_W-1:0] tx_prev;
  reg tx_low_done;
  wire tx_empty = (tx_count == 7'h00) &&
    (!feature_ctrl_reg[`UCIP_FEAT_RS485] || tx_shift_empty);
  wire tx_below = fifo_en && tx_count < tx_level && tx_prev >= tx_level;
  reg tx_empty_d;
  wire tx_set = fifo_en ? (tx_below | (tx_empty & ~tx_empty_d)) :
    (tx_empty & ~tx_empty_d);
  // Set wins over clear in each pending flag
  always @(posedge clk) begin
    if (rst) begin
      ls_pend <= 1'b0;
      tx_pend <= 1'b0;
      ms_pend <= 1'b0;
      xs_pend <= 1'b0;
      pin_pend <= 1'b0;
      wake_flag <= 1'b0;
      tx_prev <= 7'h00;
      tx_empty_d <= 1'b1;
      tx_low_done <= 1'b0;
    end else begin
      tx_prev <= tx_count;
      tx_empty_d <= tx_empty;
      tx_low_done <= tx_below;
      if (|line_status[4:1]) ls_pend <= 1'b1;
      else if (rd_lsr) ls_pend <= 1'b0;
      if (tx_set) tx_pend <= 1'b1;
      else if (wr_thr || (rd_isr && held_code == `UCIP_CODE_TX)) begin
        tx_pend <= 1'b0;
      end
      if (|modem_delta) ms_pend <= 1'b1;
      else if (rd_msr) ms_pend <= 1'b0;
      if (xoff_seen || special_seen) xs_pend <= 1'b1;
      else if (rd_isr || xon_seen || rx_char_in) begin
        xs_pend <= 1'b0;
      end
      if (auto_flow && (cts_rise || rts_rise)) pin_pend <= 1'b1;
      else if (rd_msr) pin_pend <= 1'b0;
      if (wake_rise) wake_flag <= 1'b1;
      else if (rd_gir) wake_flag <= 1'b0;
    end
  end
// ****************************************
// Receive time-out timer
// ****************************************
  // Delay tracks format: char_bits and bit_clocks from the receiver
  reg [TO_W-1:0] to_cnt;
  // Product is wide; only TO_W bits are kept on purpose
  wire [31:0] to_prod = bit_clocks *
    (`UCIP_TO_CHARS * char_bits + `UCIP_TO_BITS);
  wire [TO_W-1:0] to_limit = to_prod[TO_W-1:0];
  always @(posedge clk) begin
    if (rst) begin
      to_cnt <= {TO_W{1'b0}};
      to_pend <= 1'b0;
    end else begin
      if (rx_char_in || rd_rhr || rx_count == 7'h00 || rx_pend) begin
        to_cnt <= {TO_W{1'b0}};
      end else if (to_cnt != to_limit) begin
        to_cnt <= to_cnt + 1'b1;
      end
      if (fifo_en && rx_count != 7'h00 && !rx_pend &&
          to_cnt == to_limit && to_limit != 0) begin
        to_pend <= 1'b1;
      end else if (rd_rhr) begin
        to_pend <= 1'b0;
      end
    end
  end
// ****************************************
// Priority encoder
// ****************************************
  wire [7:0] ie = irq_enable_reg;
  always @* begin
    cur_code = `UCIP_CODE_NONE;
    if (ie[`UCIP_IE_LS] && ls_pend) cur_code = `UCIP_CODE_LS;
    else if (ie[`UCIP_IE_RX] && rx_pend) cur_code = `UCIP_CODE_RX;
    else if (ie[`UCIP_IE_RX] && to_pend) cur_code = `UCIP_CODE_TO;
    else if (ie[`UCIP_IE_TX] && tx_pend) cur_code = `UCIP_CODE_TX;
    else if (ie[`UCIP_IE_MS] && ms_pend) cur_code = `UCIP_CODE_MS;
    else if (ie[`UCIP_IE_XOFF] && xs_pend) cur_code = `UCIP_CODE_XS;
    else if ((ie[`UCIP_IE_CTS] || ie[`UCIP_IE_RTS]) && pin_pend) begin
      cur_code = `UCIP_CODE_PIN;
    end
  end
  // Latched code holds until its source is serviced
  reg [5:0] next_held;
  always @* begin
    next_held = held_code;
    if (held_code == `UCIP_CODE_NONE || !still_pending) begin
      next_held = cur_code;
    end
  end
  always @* begin
    case (held_code)
      `UCIP_CODE_LS: still_pending = ls_pend && ie[`UCIP_IE_LS];
      `UCIP_CODE_RX: still_pending = rx_pend && ie[`UCIP_IE_RX];
      `UCIP_CODE_TO: still_pending = to_pend && ie[`UCIP_IE_RX];
      `UCIP_CODE_TX: still_pending = tx_pend && ie[`UCIP_IE_TX];
      `UCIP_CODE_MS: still_pending = ms_pend && ie[`UCIP_IE_MS];
      `UCIP_CODE_XS: still_pending = xs_pend && ie[`UCIP_IE_XOFF];
      `UCIP_CODE_PIN: still_pending = pin_pend;
      default: still_pending = 1'b0;
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      held_code <= `UCIP_CODE_NONE;
      irq <= 1'b0;
      rdata <= `UCIP_RST_8;
    end else begin
      held_code <= next_held;
      irq <= next_held != `UCIP_CODE_NONE;
      rdata <= `UCIP_RST_8;
      if (rd) begin
        case (addr)
          `UCIP_ADDR_IER: rdata <= irq_enable_reg;
          `UCIP_ADDR_ISR: rdata <= {{2{fifo_en}}, held_code};
          `UCIP_ADDR_FEAT: rdata <= feature_ctrl_reg;
          `UCIP_ADDR_EFR: rdata <= enhanced_feature_reg;
          `UCIP_ADDR_LSR: rdata <= line_status;
          `UCIP_ADDR_GIRQ: rdata <= {7'h00, wake_flag};
          default: rdata <= `UCIP_RST_8;
        endcase
      end
    end
  end
endmodule // ucip_irq

// ==== testbench/ucip_irq_monitor.sv ====
// ****************
// Port checker
// ****************
module ucip_irq_monitor (
  input wire clk,
  input wire rst,
  input wire [2:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire [7:0] line_status,
  input wire [3:0] modem_delta,
  input wire fifo_en,
  input wire wake_flag,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mirror of enables; bench sets enhanced bit before high bits
  logic [7:0] ier_m;
  always_ff @(posedge clk) begin
    if (rst) ier_m <= 8'h00;
    else if (wr && addr == 3'h1) ier_m <= wdata;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not zero");
  a_isr_fifo_bits: assert property (rd && addr == 3'h2 |=>
    rdata[7:6] == {2{$past(fifo_en)}}) else $error("fifo bits");
  a_code_legal: assert property (rd && addr == 3'h2 |=>
    rdata[5:0] inside {6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20,
    6'h01}) else $error("bad code");
  a_none_bit0: assert property (rd && addr == 3'h2 |=>
    rdata[0] == (rdata[5:0] == 6'h01)) else $error("bit0 wrong");
  a_line_raise: assert property (ier_m[2] && line_status[4:1] != 0
    |-> ##[1:6] irq) else $error("no line irq");
  a_modem_raise: assert property (ier_m[3] && modem_delta != 0
    |-> ##[1:6] irq) else $error("no modem irq");
  a_idle_quiet: assert property ((ier_m == 8'h00) [*3] |-> !irq)
    else $error("irq while disabled");
  a_fifo_follow: assert property (wr && addr == 3'h2 |=>
    fifo_en == $past(wdata[0])) else $error("fifo enable");
  a_wake_clear: assert property (rd && addr == 3'h7 |->
    ##[1:2] !wake_flag) else $error("wake not cleared");
endmodule // ucip_irq_monitor

// ==== testbench/ucip_serial_model.sv ====
// ****************
// Line side events
// ****************
module ucip_serial_model (
  input wire clk,
  input wire go,
  input wire [1:0] sel,
  output logic [3:0] modem_delta,
  output logic xoff_seen,
  output logic special_seen,
  output logic rx_char_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // One-cycle pulses, as the receiver would flag them
  always @(posedge clk) begin
    modem_delta <= (go && sel == 2'h0) ? 4'h1 : 4'h0;
    xoff_seen <= go && sel == 2'h1;
    special_seen <= go && sel == 2'h2;
    rx_char_in <= go && sel == 2'h3;
  end
endmodule // ucip_serial_model

// ==== testbench/uart_channel_irq_prioritizer_tb.sv ====
// ****************
// Bench top
// ****************
module uart_channel_irq_prioritizer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, go = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00, line_status = 8'h00, got;
  logic [6:0] rx_count = 7'h00, tx_count = 7'h01;
  logic [1:0] sel = 2'h0;
  logic auto_flow = 1'b0, cts_pin = 1'b0, sleep_mode = 1'b0;
  logic rts_out = 1'b0, tx_shift_empty = 1'b1;
  wire [7:0] rdata;
  wire [3:0] modem_delta;
  wire xoff_seen, special_seen, rx_char_in, fifo_en, wake_flag, irq;
  int n_mismatch = 0, tests_run = 0;
  initial forever #25 clk = ~clk;
  ucip_serial_model line_side (.clk(clk), .go(go), .sel(sel),
    .modem_delta(modem_delta), .xoff_seen(xoff_seen),
    .special_seen(special_seen), .rx_char_in(rx_char_in));
  // Timing inputs tied: time-out is not exercised here
  ucip_irq dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_count(rx_count),
    .tx_count(tx_count), .tx_shift_empty(tx_shift_empty),
    .rx_char_in(rx_char_in), .bit_clocks(5'h01), .char_bits(4'ha),
    .line_status(line_status), .modem_delta(modem_delta),
    .xoff_seen(xoff_seen), .special_seen(special_seen), .xon_seen(1'b0),
    .auto_flow(auto_flow), .cts_pin(cts_pin), .rts_out(rts_out),
    .sleep_mode(sleep_mode), .rx_prog(7'h10), .tx_prog(7'h10),
    .fifo_en(fifo_en), .wake_flag(wake_flag), .irq(irq));
  task automatic chk(input string what, input logic [7:0] exp, got_v);
    tests_run++;
    if (got_v !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got_v);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    rd_reg(a);
    chk("read data", exp, got);
  endtask
  task automatic pulse(input logic [1:0] s);
    @(posedge clk);
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Bounded wait so a dead request line cannot hang the run
  task automatic wait_sig(input logic v, input bit wk);
    for (int i = 0; i < 20 && (wk ? wake_flag : irq) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(wk ? "wake flag" : "irq", {7'h0, v}, {7'h0, wk ? wake_flag : irq});
  endtask
  task automatic wrap_up;
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(3'h2, 8'h01);
    rdc(3'h1, 8'h00);
    wr_reg(3'h1, 8'h0c);
    pulse(2'h0);
    wait_sig(1'b1, 0);
    @(posedge clk) line_status <= 8'h04;
    rdc(3'h2, 8'h00);
    rd_reg(3'h6);
    rdc(3'h2, 8'h06);
    @(posedge clk) line_status <= 8'h00;
    rd_reg(3'h5);
    rdc(3'h2, 8'h01);
    wait_sig(1'b0, 0);
    wr_reg(3'h1, 8'h02);
    @(posedge clk) tx_count <= 7'h00;
    wait_sig(1'b1, 0);
    rdc(3'h2, 8'h02);
    rdc(3'h2, 8'h01);
    @(posedge clk) tx_count <= 7'h01;
    @(posedge clk) tx_count <= 7'h00;
    wait_sig(1'b1, 0);
    @(posedge clk) tx_count <= 7'h01;
    wr_reg(3'h0, 8'h55);
    rdc(3'h2, 8'h01);
    wr_reg(3'h4, 8'h10);
    wr_reg(3'h1, 8'h20);
    pulse(2'h1);
    wait_sig(1'b1, 0);
    rdc(3'h2, 8'h10);
    rdc(3'h2, 8'h01);
    pulse(2'h2);
    wait_sig(1'b1, 0);
    pulse(2'h3);
    wait_sig(1'b0, 0);
    wr_reg(3'h1, 8'h80);
    @(posedge clk) auto_flow <= 1'b1;
    @(posedge clk) cts_pin <= 1'b1;
    wait_sig(1'b1, 0);
    rdc(3'h2, 8'h20);
    rd_reg(3'h6);
    rdc(3'h2, 8'h01);
    wr_reg(3'h1, 8'h01);
    wr_reg(3'h2, 8'h01);
    rdc(3'h2, 8'hc1);
    @(posedge clk) rx_count <= 7'h01;
    wait_sig(1'b1, 0);
    rdc(3'h2, 8'hc4);
    @(posedge clk) rx_count <= 7'h00;
    wait_sig(1'b0, 0);
    wr_reg(3'h1, 8'h00);
    wr_reg(3'h2, 8'h00);
    rdc(3'h2, 8'h01);
    @(posedge clk) sleep_mode <= 1'b1;
    repeat (4) @(posedge clk);
    sleep_mode <= 1'b0;
    wait_sig(1'b1, 1);
    rd_reg(3'h7);
    chk("global", 8'h01, got & 8'h01);
    chk("wake flag", 8'h00, {7'h0, wake_flag});
    wrap_up();
  end
endmodule // uart_channel_irq_prioritizer_tb
bind ucip_irq ucip_irq_monitor u_mon (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .line_status(line_status), .modem_delta(modem_delta),
  .fifo_en(fifo_en), .wake_flag(wake_flag), .irq(irq));
